/* File: rtl/wotf_top.sv */
// Waveform output timing, sample FIFO and shared pin routing
`timescale 1ns/1ns
module wotf_top
  import wotf_pkg::*;
(
  // Clock, reset and enable
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  input  wire logic              CE,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  // Converters
  output wotf_sample_s           DAC_CODE,
  output logic                   DAC_LOAD,
  output logic      [NUM_CH-1:0] REF_SEL_EXT,
  // Update clock shared pin
  input  wire logic              UPDATE_CLOCK_SHARED_PIN_I,
  output logic                   UPDATE_CLOCK_SHARED_PIN_O,
  output logic                   UPDATE_CLOCK_SHARED_PIN_OE,
  // Start trigger shared pin
  input  wire logic              START_TRIGGER_SHARED_PIN_I,
  output logic                   START_TRIGGER_SHARED_PIN_O,
  output logic                   START_TRIGGER_SHARED_PIN_OE,
  // Counter 0 source shared pin
  input  wire logic              COUNTER0_SOURCE_SHARED_PIN_I,
  output logic                   COUNTER0_SOURCE_SHARED_PIN_O,
  output logic                   COUNTER0_SOURCE_SHARED_PIN_OE,
  // Counter 0 gate shared pin
  input  wire logic              COUNTER0_GATE_SHARED_PIN_I,
  output logic                   COUNTER0_GATE_SHARED_PIN_O,
  output logic                   COUNTER0_GATE_SHARED_PIN_OE,
  // Counter 0 output pin
  input  wire logic              COUNTER0_OUT_PIN_I,
  output logic                   COUNTER0_OUT_PIN_O,
  output logic                   COUNTER0_OUT_PIN_OE,
  // Fixed output pins
  output logic                   COUNTER1_OUT_PIN_O,
  output logic                   FREQ_GENERATOR_OUT_PIN,
  // Counter and frequency generator
  input  wire logic              COUNTER0_INTERNAL_OUT,
  input  wire logic              COUNTER1_INTERNAL_OUT,
  input  wire logic              FREQ_GEN_OUT,
  input  wire logic              COUNTER0_ALT_SOURCE,
  input  wire logic              COUNTER0_ALT_GATE,
  output logic                   COUNTER0_SOURCE_SIGNAL,
  output logic                   COUNTER0_GATE_SIGNAL,
  // Inter-board sync bus
  output logic      [SYNC_N-1:0] INTER_BOARD_SYNC_BUS_O,
  output logic      [SYNC_N-1:0] INTER_BOARD_SYNC_BUS_OE
);
  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic [FIFO_AW:0] fill(input logic [FIFO_AW:0] w,
                                            input logic [FIFO_AW:0] r);
    fill = w - r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  wotf_state_e       state_reg;
  logic              trig_sel_reg;
  logic [PIN_N-1:0]  pindir_reg;
  logic [PER_W-1:0]  period_reg;
  logic [SYNC_N-1:0] route_reg;
  logic [1:0]        srcsel_reg;
  logic              underflow_reg;
  logic              overflow_reg;
  logic [FIFO_AW:0]  wr_ptr_reg;
  logic [FIFO_AW:0]  rd_ptr_reg;
  logic              pop_d_reg;
  logic              strt_prev_reg;
  logic              start_pulse_reg;
  logic              tick;
  logic              uclk;
  logic              empty;
  logic              full;
  logic              push;
  logic              pop;
  logic              ufl_evt;
  logic              sw_start;
  logic              sw_stop;
  logic              hw_start;
  logic              start_evt;
  logic              running;
  logic              src_sel;
  logic              gate_sel;
  wotf_sample_s      rd_sample;

  assign empty    = (fill(wr_ptr_reg, rd_ptr_reg) == '0);
  assign full     = (fill(wr_ptr_reg, rd_ptr_reg) ==
                     {1'b1, {FIFO_AW{1'b0}}});
  assign running  = (state_reg == WOTF_RUN);
  assign push     = WR && hit(ADDR, ADDR_FIFO) && !full; // RL2
  assign pop      = tick && running && !empty; // RL1
  assign ufl_evt  = tick && running && empty; // RL17
  assign sw_start = WR && hit(ADDR, ADDR_CTRL) && WDATA[CTRL_START];
  assign sw_stop  = WR && hit(ADDR, ADDR_CTRL) && WDATA[CTRL_STOP];
  assign hw_start = !trig_sel_reg && !pindir_reg[PIN_STRT] &&
                    START_TRIGGER_SHARED_PIN_I && !strt_prev_reg; // RL5
  assign start_evt = !running && (sw_start || hw_start); // RL15
  assign src_sel  = srcsel_reg[0] ? COUNTER0_ALT_SOURCE
                                  : COUNTER0_SOURCE_SHARED_PIN_I; // RL6
  assign gate_sel = srcsel_reg[1] ? COUNTER0_ALT_GATE
                                  : COUNTER0_GATE_SHARED_PIN_I; // RL7

  // -----------------------------------------------------------------------
  // Sample storage and update clock
  // -----------------------------------------------------------------------
  wotf_mem u_mem (
    .clk   (CLOCK),
    .ce    (CE),
    .we    (push),
    .waddr (wr_ptr_reg[FIFO_AW-1:0]),
    .wdata (wotf_sample_s'(WDATA)),
    .re    (pop),
    .raddr (rd_ptr_reg[FIFO_AW-1:0]),
    .rdata (rd_sample)
  );

  wotf_tick u_tick (
    .clk    (CLOCK),
    .rst_b  (RST_B),
    .ce     (CE),
    .run    (running),
    .period (period_reg),
    .tick   (tick),
    .uclk   (uclk)
  );

  // -----------------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      trig_sel_reg <= 1'b0;
      pindir_reg   <= PINDIR_RST; // RL16
      period_reg   <= PERIOD_RST;
      REF_SEL_EXT  <= REFSEL_RST;
      route_reg    <= '0;
      srcsel_reg   <= '0;
    end else if (CE && WR) begin
      if (hit(ADDR, ADDR_CTRL)) begin
        trig_sel_reg <= WDATA[CTRL_TRIG_SEL];
      end
      if (hit(ADDR, ADDR_PINDIR)) begin
        pindir_reg <= WDATA[PIN_N-1:0];
      end
      if (hit(ADDR, ADDR_PERIOD)) begin
        period_reg <= (WDATA[PER_W-1:0] < PERIOD_MIN) ? PERIOD_MIN
                                                       : WDATA[PER_W-1:0];
      end
      if (hit(ADDR, ADDR_REFSEL)) begin
        REF_SEL_EXT <= WDATA[NUM_CH-1:0]; // RL12
      end
      if (hit(ADDR, ADDR_ROUTE)) begin
        route_reg <= WDATA[SYNC_N-1:0];
      end
      if (hit(ADDR, ADDR_SRCSEL)) begin
        srcsel_reg <= WDATA[1:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Generation state and start trigger
  // -----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= WOTF_IDLE;
    end else if (CE) begin
      case (state_reg)
        WOTF_IDLE: begin
          if (start_evt) begin
            state_reg <= WOTF_RUN; // RL15
          end
        end
        WOTF_RUN: begin
          if (sw_stop) begin
            state_reg <= WOTF_IDLE;
          end
        end
        default: begin
          state_reg <= WOTF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      strt_prev_reg   <= 1'b0;
      start_pulse_reg <= 1'b0;
    end else if (CE) begin
      strt_prev_reg   <= START_TRIGGER_SHARED_PIN_I;
      start_pulse_reg <= start_evt; // RL16
    end
  end

  // -----------------------------------------------------------------------
  // FIFO pointers and flags
  // -----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (CE) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 9'h001; // RL2
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 9'h001; // RL1
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      underflow_reg <= 1'b0;
      overflow_reg  <= 1'b0;
    end else if (CE) begin
      if (ufl_evt) begin
        underflow_reg <= 1'b1; // RL17
      end else if (WR && hit(ADDR, ADDR_STATUS) && WDATA[ST_UNDER]) begin
        underflow_reg <= 1'b0;
      end
      if (WR && hit(ADDR, ADDR_FIFO) && full) begin
        overflow_reg <= 1'b1;
      end else if (WR && hit(ADDR, ADDR_STATUS) && WDATA[ST_OVER]) begin
        overflow_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Converter load
  // -----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pop_d_reg <= 1'b0;
      DAC_LOAD  <= 1'b0;
      DAC_CODE  <= '0;
    end else if (CE) begin
      pop_d_reg <= pop;
      DAC_LOAD  <= pop_d_reg; // RL14
      if (pop_d_reg) begin
        DAC_CODE <= rd_sample; // RL13
      end
    end
  end

  // -----------------------------------------------------------------------
  // Shared pins, counter routing and sync bus
  // -----------------------------------------------------------------------
  assign UPDATE_CLOCK_SHARED_PIN_O = uclk; // RL3

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      UPDATE_CLOCK_SHARED_PIN_OE    <= 1'b0;
      START_TRIGGER_SHARED_PIN_O    <= 1'b0;
      START_TRIGGER_SHARED_PIN_OE   <= 1'b0;
      COUNTER0_SOURCE_SHARED_PIN_O  <= 1'b0;
      COUNTER0_SOURCE_SHARED_PIN_OE <= 1'b0;
      COUNTER0_GATE_SHARED_PIN_O    <= 1'b0;
      COUNTER0_GATE_SHARED_PIN_OE   <= 1'b0;
      COUNTER0_OUT_PIN_O            <= 1'b0;
      COUNTER0_OUT_PIN_OE           <= 1'b0;
      COUNTER1_OUT_PIN_O            <= 1'b0;
      FREQ_GENERATOR_OUT_PIN        <= 1'b0;
      COUNTER0_SOURCE_SIGNAL        <= 1'b0;
      COUNTER0_GATE_SIGNAL          <= 1'b0;
    end else if (CE) begin
      UPDATE_CLOCK_SHARED_PIN_OE    <= pindir_reg[PIN_UCLK]; // RL3
      START_TRIGGER_SHARED_PIN_O    <= start_pulse_reg; // RL4
      START_TRIGGER_SHARED_PIN_OE   <= pindir_reg[PIN_STRT]; // RL16
      COUNTER0_SOURCE_SHARED_PIN_O  <= src_sel; // RL8
      COUNTER0_SOURCE_SHARED_PIN_OE <= pindir_reg[PIN_SRC];
      COUNTER0_GATE_SHARED_PIN_O    <= gate_sel; // RL8
      COUNTER0_GATE_SHARED_PIN_OE   <= pindir_reg[PIN_GATE];
      COUNTER0_OUT_PIN_O            <= COUNTER0_INTERNAL_OUT; // RL9
      COUNTER0_OUT_PIN_OE           <= pindir_reg[PIN_C0O];
      COUNTER1_OUT_PIN_O            <= COUNTER1_INTERNAL_OUT; // RL9
      FREQ_GENERATOR_OUT_PIN        <= FREQ_GEN_OUT; // RL11
      COUNTER0_SOURCE_SIGNAL        <= src_sel; // RL6
      COUNTER0_GATE_SIGNAL          <= gate_sel; // RL7
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      INTER_BOARD_SYNC_BUS_O  <= '0;
      INTER_BOARD_SYNC_BUS_OE <= '0;
    end else if (CE) begin
      INTER_BOARD_SYNC_BUS_O  <= {COUNTER0_OUT_PIN_I,
                                  COUNTER0_GATE_SHARED_PIN_I,
                                  COUNTER0_SOURCE_SHARED_PIN_I};
      INTER_BOARD_SYNC_BUS_OE[RT_SRC]  <= route_reg[RT_SRC] &&
                                          !pindir_reg[PIN_SRC]; // RL6
      INTER_BOARD_SYNC_BUS_OE[RT_GATE] <= route_reg[RT_GATE] &&
                                          !pindir_reg[PIN_GATE]; // RL7
      INTER_BOARD_SYNC_BUS_OE[RT_C0O]  <= route_reg[RT_C0O] &&
                                          !pindir_reg[PIN_C0O]; // RL10
    end
  end

  // -----------------------------------------------------------------------
  // Register read
  // -----------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= '0;
    end else if (CE && RD) begin
      RDATA <= '0;
      case (ADDR)
        ADDR_CTRL:   RDATA[CTRL_TRIG_SEL] <= trig_sel_reg;
        ADDR_PINDIR: RDATA[PIN_N-1:0] <= pindir_reg;
        ADDR_PERIOD: RDATA[PER_W-1:0] <= period_reg;
        ADDR_REFSEL: RDATA[NUM_CH-1:0] <= REF_SEL_EXT;
        ADDR_ROUTE:  RDATA[SYNC_N-1:0] <= route_reg;
        ADDR_SRCSEL: RDATA[1:0] <= srcsel_reg;
        ADDR_STATUS: begin
          RDATA[ST_RUN]   <= running;
          RDATA[ST_UNDER] <= underflow_reg; // RL17
          RDATA[ST_EMPTY] <= empty;
          RDATA[ST_FULL]  <= full;
          RDATA[ST_OVER]  <= overflow_reg;
          RDATA[ST_PINS +: PIN_N] <= {COUNTER0_OUT_PIN_I,
                                      COUNTER0_GATE_SHARED_PIN_I,
                                      COUNTER0_SOURCE_SHARED_PIN_I,
                                      START_TRIGGER_SHARED_PIN_I,
                                      UPDATE_CLOCK_SHARED_PIN_I}; // RL5
          RDATA[ST_COUNT +: FIFO_AW+1] <= fill(wr_ptr_reg, rd_ptr_reg);
        end
        default: RDATA <= '0;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B || !CE);

  sequence s_pop;
    tick && running && !empty;
  endsequence

  sequence s_load;
    ##1 pop_d_reg ##1 DAC_LOAD;
  endsequence

  chk_pop_advance: assert property ( // RL1
    s_pop |=> rd_ptr_reg == $past(rd_ptr_reg) + 9'h001)
    else $error("tick did not take one sample");

  chk_load_follow: assert property ( // RL14
    s_pop |-> s_load)
    else $error("converter load missing after pop");

  chk_underflow_set: assert property ( // RL17
    ufl_evt |=> underflow_reg && !DAC_LOAD ##1 !DAC_LOAD)
    else $error("underflow not flagged or code changed");

  chk_uclk_fall: assert property ( // RL3
    tick |-> !UPDATE_CLOCK_SHARED_PIN_O && $past(UPDATE_CLOCK_SHARED_PIN_O))
    else $error("update clock did not fall at tick");

  chk_start_pulse: assert property ( // RL4
    start_evt |=> ##1 START_TRIGGER_SHARED_PIN_O ##1
    !START_TRIGGER_SHARED_PIN_O)
    else $error("start trigger pulse wrong");

  chk_sw_start: assert property ( // RL15
    sw_start && !running |=> running)
    else $error("software start did not start");

  chk_src_route: assert property (!srcsel_reg[0] |=> // RL6
    COUNTER0_SOURCE_SIGNAL == $past(COUNTER0_SOURCE_SHARED_PIN_I))
    else $error("counter 0 source routing wrong");

  chk_gate_route: assert property (!srcsel_reg[1] |=> // RL7
    COUNTER0_GATE_SIGNAL == $past(COUNTER0_GATE_SHARED_PIN_I))
    else $error("counter 0 gate routing wrong");

  chk_ctr1_out: assert property ( // RL9
    1'b1 |=> COUNTER1_OUT_PIN_O == $past(COUNTER1_INTERNAL_OUT))
    else $error("counter 1 output pin wrong");
endmodule

/* File: rtl/wotf_pkg.sv */
// Constants and types for the waveform output timing block
// -------------------------------------------------------------------------
// Overview of operation
// RL1: Each update clock tick with the FIFO not empty takes one sample word and loads the converters.
// RL2: Sample FIFO holds a whole waveform between host and converters.
// RL3: Update clock pin as output shows the clock; falling edge marks a sample.
// RL4: Start pin as output shows the start trigger; rising edge marks start.
// RL5: Start trigger comes from the start pin unless software-only is chosen.
// RL6: Counter 0 source comes from its shared pin by default; may feed sync bus.
// RL7: Counter 0 gate comes from its shared pin by default; may feed sync bus.
// RL8: Source and gate pins as outputs carry the selected counter 0 signals.
// RL9: Counter 0 out pin carries counter 0 output; counter 1 pin always does.
// RL10: Counter 0 out pin as input can be routed onto the sync bus.
// RL11: Frequency output pin carries the frequency generator output.
// RL12: Each channel selects internal or external reference for its range.
// RL13: Converter codes are 16 bits wide.
// RL14: One update clock loads all channels at the same instant.
// RL15: Without hardware trigger, a software start command begins generation.
// RL16: Start pin resets as input; as output gives an active-high pulse.
// RL17: Empty FIFO at a tick holds the last code and sets an underflow flag.
// -------------------------------------------------------------------------
package wotf_pkg;
  localparam int NUM_CH  = 2;
  localparam int CODE_W  = 16;
  localparam int FIFO_AW = 8;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int PIN_N   = 5;
  localparam int SYNC_N  = 3;
  localparam int PER_W   = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PINDIR = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_FIFO   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_REFSEL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_SRCSEL = 8'h1C;

  // Control bits
  localparam int CTRL_START    = 0;
  localparam int CTRL_STOP     = 1;
  localparam int CTRL_TRIG_SEL = 2;

  // Pin direction bits, also sync route bits
  localparam int PIN_UCLK = 0;
  localparam int PIN_STRT = 1;
  localparam int PIN_SRC  = 2;
  localparam int PIN_GATE = 3;
  localparam int PIN_C0O  = 4;
  localparam int RT_SRC   = 0;
  localparam int RT_GATE  = 1;
  localparam int RT_C0O   = 2;

  // Status bits
  localparam int ST_RUN   = 0;
  localparam int ST_UNDER = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_FULL  = 3;
  localparam int ST_OVER  = 4;
  localparam int ST_PINS  = 8;
  localparam int ST_COUNT = 16;

  // Reset values and minimum period
  localparam logic [PER_W-1:0]  PERIOD_RST = 16'h0064;
  localparam logic [PER_W-1:0]  PERIOD_MIN = 16'h0002;
  localparam logic [PIN_N-1:0]  PINDIR_RST = 5'h00;
  localparam logic [NUM_CH-1:0] REFSEL_RST = 2'h0;

  typedef struct packed {
    logic [CODE_W-1:0] ch1;
    logic [CODE_W-1:0] ch0;
  } wotf_sample_s;

  typedef enum logic [1:0] {
    WOTF_IDLE = 2'b01,
    WOTF_RUN  = 2'b10
  } wotf_state_e;
endpackage

/* File: rtl/wotf_mem.sv */
// Sample storage with registered read data
`timescale 1ns/1ns
module wotf_mem
  import wotf_pkg::*;
(
  // Clock
  input  wire logic                 clk,
  input  wire logic                 ce,
  // Write side
  input  wire logic                 we,
  input  wire logic [FIFO_AW-1:0]   waddr,
  input  wire wotf_sample_s         wdata,
  // Read side
  input  wire logic                 re,
  input  wire logic [FIFO_AW-1:0]   raddr,
  output wotf_sample_s              rdata
);
  wotf_sample_s mem [0:(1<<FIFO_AW)-1];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* File: rtl/wotf_tick.sv */
// Update clock generator: period divider and tick pulse
`timescale 1ns/1ns
module wotf_tick
  import wotf_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // Control
  input  wire logic             run,
  input  wire logic [PER_W-1:0] period,
  // Update clock
  output logic                  tick,
  output logic                  uclk
);
  logic [PER_W-1:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
      uclk    <= 1'b1;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        cnt_reg <= '0;
        uclk    <= 1'b1;
      end else if (cnt_reg == '0) begin
        cnt_reg <= period - 16'h0001;
        tick    <= 1'b1;
        uclk    <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
        if (cnt_reg == (period >> 1)) begin
          uclk <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: bench/wotf_host_model.sv */
// Host model driving the register port
`timescale 1ns/1ns
module wotf_host_model
  import wotf_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register port
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd,
  input  wire logic [DATA_W-1:0] rdata
);
  initial begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Software start, trigger select kept in bit 2
  task automatic start_sw(input logic sw_only);
    wr_reg(ADDR_CTRL, {29'h0, sw_only, 2'b01});
  endtask
endmodule

/* File: bench/wotf_tb_top.sv */
// Testbench for the waveform output timing block
`timescale 1ns/1ns
module wotf_tb_top
  import wotf_pkg::*;
;
  logic CLOCK = 1'b0, RST_B = 1'b0, CE = 1'b1;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  logic WR, RD, DAC_LOAD;
  wotf_sample_s DAC_CODE;
  logic [NUM_CH-1:0] REF_SEL_EXT;
  logic UPDATE_CLOCK_SHARED_PIN_I, UPDATE_CLOCK_SHARED_PIN_O;
  logic UPDATE_CLOCK_SHARED_PIN_OE, START_TRIGGER_SHARED_PIN_I;
  logic START_TRIGGER_SHARED_PIN_O, START_TRIGGER_SHARED_PIN_OE;
  logic COUNTER0_SOURCE_SHARED_PIN_I, COUNTER0_SOURCE_SHARED_PIN_O;
  logic COUNTER0_SOURCE_SHARED_PIN_OE, COUNTER0_GATE_SHARED_PIN_I;
  logic COUNTER0_GATE_SHARED_PIN_O, COUNTER0_GATE_SHARED_PIN_OE;
  logic COUNTER0_OUT_PIN_I, COUNTER0_OUT_PIN_O, COUNTER0_OUT_PIN_OE;
  logic COUNTER1_OUT_PIN_O, FREQ_GENERATOR_OUT_PIN, FREQ_GEN_OUT;
  logic COUNTER0_INTERNAL_OUT, COUNTER1_INTERNAL_OUT;
  logic COUNTER0_ALT_SOURCE, COUNTER0_ALT_GATE;
  logic COUNTER0_SOURCE_SIGNAL, COUNTER0_GATE_SIGNAL;
  logic [SYNC_N-1:0] INTER_BOARD_SYNC_BUS_O, INTER_BOARD_SYNC_BUS_OE;
  logic [4:0] ext = 5'h00;
  logic [31:0] d;
  int fails = 0, checks = 0, cyc = 0, fall = 0, strt = 0;
  logic uc_d = 1'b1;
  wotf_sample_s got_q[$];
  wotf_sample_s smp[3] = '{32'h8000_7FFF, 32'hFFFF_0000, 32'h1234_ABCD};

  // Pin level from the DUT's enable, else the external level
  assign UPDATE_CLOCK_SHARED_PIN_I = UPDATE_CLOCK_SHARED_PIN_OE ?
                                     UPDATE_CLOCK_SHARED_PIN_O : ext[0];
  assign START_TRIGGER_SHARED_PIN_I = START_TRIGGER_SHARED_PIN_OE ?
                                      START_TRIGGER_SHARED_PIN_O : ext[1];
  assign COUNTER0_SOURCE_SHARED_PIN_I = COUNTER0_SOURCE_SHARED_PIN_OE ?
                                        COUNTER0_SOURCE_SHARED_PIN_O : ext[2];
  assign COUNTER0_GATE_SHARED_PIN_I = COUNTER0_GATE_SHARED_PIN_OE ?
                                      COUNTER0_GATE_SHARED_PIN_O : ext[3];
  assign COUNTER0_OUT_PIN_I = COUNTER0_OUT_PIN_OE ?
                              COUNTER0_OUT_PIN_O : ext[4];
  wire [4:0] oe = {COUNTER0_OUT_PIN_OE, COUNTER0_GATE_SHARED_PIN_OE,
                   COUNTER0_SOURCE_SHARED_PIN_OE, START_TRIGGER_SHARED_PIN_OE,
                   UPDATE_CLOCK_SHARED_PIN_OE};
  wire [6:0] rt = {COUNTER0_SOURCE_SHARED_PIN_O, COUNTER0_GATE_SHARED_PIN_O,
                   COUNTER0_OUT_PIN_O, COUNTER1_OUT_PIN_O,
                   FREQ_GENERATOR_OUT_PIN, COUNTER0_SOURCE_SIGNAL,
                   COUNTER0_GATE_SIGNAL};
  wire [7:0] sy = {INTER_BOARD_SYNC_BUS_OE, INTER_BOARD_SYNC_BUS_O,
                   COUNTER0_SOURCE_SIGNAL, COUNTER0_GATE_SIGNAL};

  wotf_host_model i_host (.clk(CLOCK), .addr(ADDR), .wdata(WDATA), .wr(WR),
                          .rd(RD), .rdata(RDATA));
  wotf_top i_dut (.*);

  always #5 CLOCK = ~CLOCK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic endt(input string name);
    $display("test %s finished", name);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Converter load monitor
  // -------------------------------------------------------------------
  always @(posedge CLOCK) begin
    cyc  <= cyc + 1;
    uc_d <= UPDATE_CLOCK_SHARED_PIN_O;
    if (uc_d === 1'b1 && UPDATE_CLOCK_SHARED_PIN_O === 1'b0) fall <= cyc;
    if (START_TRIGGER_SHARED_PIN_O === 1'b1) strt <= strt + 1;
    if (DAC_LOAD === 1'b1) begin
      got_q.push_back(DAC_CODE);
      chk(32'(cyc - fall), 32'h2);
    end
  end

  initial begin
    #100000;
    fails++;
    complete_run();
  end

  // -------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------
  initial begin
    {COUNTER0_INTERNAL_OUT, COUNTER1_INTERNAL_OUT, FREQ_GEN_OUT,
     COUNTER0_ALT_SOURCE, COUNTER0_ALT_GATE} = 5'h00;
    repeat (12) @(posedge CLOCK);
    RST_B <= 1'b1;
    chk({26'h0, oe, UPDATE_CLOCK_SHARED_PIN_O}, 32'h1);
    i_host.rd_reg(ADDR_PINDIR, d);
    chk(d, 32'h0);
    i_host.rd_reg(8'h20, d);
    chk(d, 32'h0);
    endt("reset");
    for (int i = 0; i < 4; i++) begin
      i_host.wr_reg(ADDR_REFSEL, i);
      i_host.rd_reg(ADDR_REFSEL, d);
      chk(d, i);
      chk(32'(REF_SEL_EXT), i);
    end
    CE <= 1'b0;
    i_host.wr_reg(ADDR_REFSEL, 32'h0);
    CE <= 1'b1;
    i_host.rd_reg(ADDR_REFSEL, d);
    chk(d, 32'h3);
    endt("reference");
    i_host.wr_reg(ADDR_PERIOD, 32'h4);
    i_host.wr_reg(ADDR_PINDIR, 32'h3);
    foreach (smp[k]) i_host.wr_reg(ADDR_FIFO, smp[k]);
    i_host.rd_reg(ADDR_STATUS, d);
    chk(32'(d[24:16]), 32'h3);
    i_host.start_sw(1'b1);
    for (int n = 0; n < 20 && d[ST_UNDER] !== 1'b1; n++)
      i_host.rd_reg(ADDR_STATUS, d);
    chk(32'(d[ST_UNDER]), 32'h1);
    chk(got_q.size(), 32'h3);
    foreach (smp[k]) chk(got_q[k], smp[k]);
    chk(DAC_CODE, smp[2]);
    chk(strt, 32'h1);
    chk(32'(oe), 32'h3);
    i_host.wr_reg(ADDR_CTRL, 32'h6);
    endt("waveform");
    i_host.wr_reg(ADDR_STATUS, 32'h12);
    i_host.wr_reg(ADDR_PINDIR, 32'h0);
    i_host.wr_reg(ADDR_CTRL, 32'h0);
    i_host.rd_reg(ADDR_STATUS, d);
    chk(32'(d[ST_RUN]), 32'h0);
    @(posedge CLOCK) ext <= 5'h02;
    i_host.rd_reg(ADDR_STATUS, d);
    chk(32'(d[ST_RUN]), 32'h1);
    chk(32'(d[12:8]), 32'h2);
    i_host.wr_reg(ADDR_CTRL, 32'h2);
    endt("hardware start");
    i_host.wr_reg(ADDR_PINDIR, 32'h1C);
    i_host.wr_reg(ADDR_SRCSEL, 32'h3);
    for (int p = 0; p < 2; p++) begin
      @(posedge CLOCK);
      {COUNTER0_INTERNAL_OUT, COUNTER1_INTERNAL_OUT, FREQ_GEN_OUT,
       COUNTER0_ALT_SOURCE, COUNTER0_ALT_GATE} <= p ? 5'h09 : 5'h16;
      repeat (3) @(posedge CLOCK);
      chk(32'(rt), p ? 32'h29 : 32'h56);
    end
    i_host.wr_reg(ADDR_PINDIR, 32'h0);
    i_host.wr_reg(ADDR_SRCSEL, 32'h0);
    i_host.wr_reg(ADDR_ROUTE, 32'h7);
    for (int p = 0; p < 2; p++) begin
      @(posedge CLOCK) ext <= p ? 5'h08 : 5'h14;
      repeat (3) @(posedge CLOCK);
      chk(32'(sy), p ? 32'hE9 : 32'hF6);
    end
    endt("routing");
    complete_run();
  end
endmodule
